// ==== dscfg_pkg.sv ====
// Package: register map, field layout, timing and types of the config port
`default_nettype none
package dscfg_pkg;

  // Clock rate of i_clk_sys
  localparam int CLK_MHZ = 50;

  // Serial frame: R/W bit, 15-bit address, one data byte
  localparam logic [4:0] SPI_INSTR_BITS = 5'd16;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd24;

  // Register offsets handled individually
  localparam logic [14:0] A_PORT_CFG = 15'h000;
  localparam logic [14:0] A_PWR_CTRL = 15'h011;
  localparam logic [14:0] A_IRQ_EN = 15'h01F;
  localparam logic [14:0] A_IRQ_STAT = 15'h023;
  localparam logic [14:0] A_CLK_PWR = 15'h080;
  localparam logic [14:0] A_SYSREF_CTL = 15'h081;
  localparam logic [14:0] A_PLL_EN = 15'h083;
  localparam logic [14:0] A_PLL_STAT = 15'h084;
  localparam logic [14:0] A_FB_DIV = 15'h085;
  localparam logic [14:0] A_TEMP_EN = 15'h12F;
  localparam logic [14:0] A_TEMP_LO = 15'h132;
  localparam logic [14:0] A_TEMP_HI = 15'h133;
  localparam logic [14:0] A_TEMP_TRIG = 15'h134;
  localparam logic [14:0] A_PLL_PWRM = 15'h1B0;

  // Plain read/write settings: loop filter, dividers, lookups, lanes
  localparam int N_GEN = 22;
  localparam logic [4:0] GEN_NONE = 5'h1F;
  localparam logic [14:0] GEN_ADDR [N_GEN] = '{
    15'h087, 15'h088, 15'h089, 15'h08A, 15'h08B, 15'h08C, 15'h08D,
    15'h12D, 15'h146, 15'h1B5, 15'h1B9, 15'h1BB, 15'h1BC, 15'h1BE,
    15'h1BF, 15'h1C0, 15'h1C1, 15'h1C4, 15'h1C5, 15'h232, 15'h2A4,
    15'h333};

  // Field positions
  localparam int PORT_RST_HI = 7;
  localparam int PORT_RST_LO = 0;
  localparam int PORT_4W_HI = 4;
  localparam int PORT_4W_LO = 3;
  localparam int PWR_BG_PD = 7;
  localparam int PWR_DAC0_PD = 6;
  localparam int PWR_DAC1_PD = 4;
  localparam int PWR_BIAS_PD = 2;
  localparam int PLL_EN_BIT = 4;
  localparam int PLL_LOCK_BIT = 1;
  localparam int IRQ_LOCK_BIT = 4;
  localparam int IRQ_LOST_BIT = 5;
  localparam int TEMP_EN_BIT = 0;
  localparam int TEMP_TRIG_BIT = 0;
  localparam logic [7:0] IRQ_MASK = 8'h30;

  // Values after reset
  localparam logic [7:0] RST_PORT_CFG = 8'h00;
  localparam logic [7:0] RST_PWR_CTRL = 8'hD4;
  localparam logic [7:0] RST_CLK_PWR = 8'hFF;
  localparam logic [7:0] RST_SYSREF = 8'h01;
  localparam logic [7:0] RST_PLL_PWRM = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Timing: least times, rounded up to whole cycles
  localparam int PLL_LOCK_NS = 10000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int TEMP_CONV_NS = 2000;
  localparam int TEMP_CONV_CYC = (TEMP_CONV_NS * CLK_MHZ + 999) / 1000;

  // One access from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] data;
  } dscfg_acc_t;

  // Power and status levels toward the analog blocks
  typedef struct packed {
    logic bandgap_en;
    logic bias_en;
    logic dac0_en;
    logic dac1_en;
    logic clk_en;
    logic sysref_en;
    logic pll_locked;
  } dscfg_pwr_t;

  // Write strobe for one offset
  function automatic logic hit(input dscfg_acc_t a, input logic [14:0] off);
    return a.wr && (a.addr == off);
  endfunction : hit

  // Index of a plain setting register, GEN_NONE when unmapped
  function automatic logic [4:0] gen_idx(input logic [14:0] a);
    logic [4:0] r;
    r = GEN_NONE;
    for (int i = 0; i < N_GEN; i++) begin
      if (GEN_ADDR[i] == a) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : gen_idx

endpackage : dscfg_pkg
`default_nettype wire

// ==== dscfg_spi.sv ====
// Serial configuration port slave: pin sampling, framing, read shift-out
`timescale 1ns/1ns
`default_nettype none
module dscfg_spi
  import dscfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_sdio,
  input wire logic i_four_wire,
  input wire logic [7:0] i_rdata,
  output dscfg_acc_t o_acc,
  output logic o_sdo,
  output logic o_sdio,
  output logic o_sdio_oe
);
  logic [2:0] sclk_s_r, csb_s_r, sdi_s_r;
  logic sclk_f_r, csb_f_r, sdi_f_r, sclk_q_r;
  logic rise, fall, rw_r;
  logic [4:0] cnt_r;
  logic [22:0] sh_r;
  logic [7:0] out_r;
  logic sdo_r;

  ////////////////////////////////////////////////////////////////////////
  // Three-stage pin sampling; a level counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_s_r <= 3'h0;
      csb_s_r <= 3'h7;
      sdi_s_r <= 3'h0;
      sclk_f_r <= 1'b0;
      csb_f_r <= 1'b1;
      sdi_f_r <= 1'b0;
      sclk_q_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], i_sclk};
      csb_s_r <= {csb_s_r[1:0], i_csb_n};
      sdi_s_r <= {sdi_s_r[1:0], i_sdio};
      if (sclk_s_r[1] == sclk_s_r[2]) sclk_f_r <= sclk_s_r[2];
      if (csb_s_r[1] == csb_s_r[2]) csb_f_r <= csb_s_r[2];
      if (sdi_s_r[1] == sdi_s_r[2]) sdi_f_r <= sdi_s_r[2];
      sclk_q_r <= sclk_f_r;
    end
  end

  assign rise = sclk_f_r & ~sclk_q_r & ~csb_f_r;
  assign fall = ~sclk_f_r & sclk_q_r & ~csb_f_r;

  ////////////////////////////////////////////////////////////////////////
  // Framing: bits past the first byte of data are ignored
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 5'h00;
      sh_r <= 23'h000000;
      rw_r <= 1'b0;
      o_acc <= '0;
    end else begin
      o_acc.wr <= 1'b0;
      o_acc.rd <= 1'b0;
      if (csb_f_r) begin
        cnt_r <= 5'h00;
        rw_r <= 1'b0;
      end else if (rise && cnt_r < SPI_FRAME_BITS) begin
        sh_r <= {sh_r[21:0], sdi_f_r};
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == SPI_INSTR_BITS - 5'h01) begin
          rw_r <= sh_r[14];
          o_acc.addr <= {sh_r[13:0], sdi_f_r};
          o_acc.rd <= sh_r[14];
        end
        if (cnt_r == SPI_FRAME_BITS - 5'h01 && !rw_r) begin
          o_acc.wr <= 1'b1;
          o_acc.data <= {sh_r[6:0], sdi_f_r};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data goes out MSB first on falling edges of the serial clock
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_r <= 8'h00;
      sdo_r <= 1'b0;
    end else begin
      if (o_acc.rd) out_r <= i_rdata;
      if (fall && rw_r && cnt_r >= SPI_INSTR_BITS) begin
        sdo_r <= out_r[3'(SPI_FRAME_BITS - 5'h01 - cnt_r)];
      end
    end
  end

  // Three-wire mode turns the data pin round only for the read byte
  assign o_sdo = sdo_r;
  assign o_sdio = sdo_r;
  assign o_sdio_oe = !i_four_wire && rw_r && !csb_f_r &&
                     cnt_r >= SPI_INSTR_BITS;
endmodule : dscfg_spi
`default_nettype wire

// ==== dscfg_pll.sv ====
// DAC PLL lock tracker: lock after a settle time, lock and loss events
`timescale 1ns/1ns
`default_nettype none
module dscfg_pll
  import dscfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_run,
  output logic o_locked,
  output logic o_lock_evt,
  output logic o_lost_evt
);
  logic [12:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // Settle counter restarts whenever the loop is stopped
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 13'h0000;
      o_locked <= 1'b0;
      o_lock_evt <= 1'b0;
      o_lost_evt <= 1'b0;
    end else begin
      o_lock_evt <= 1'b0;
      o_lost_evt <= 1'b0;
      if (!i_run) begin
        cnt_r <= 13'h0000;
        o_locked <= 1'b0;
        o_lost_evt <= o_locked;
      end else if (cnt_r < 13'(PLL_LOCK_CYC)) begin
        cnt_r <= cnt_r + 13'h0001;
      end else if (!o_locked) begin
        o_locked <= 1'b1;
        o_lock_evt <= 1'b1;
      end
    end
  end
endmodule : dscfg_pll
`default_nettype wire

// ==== dscfg_top.sv ====
// Start-up configuration register file of a dual DAC behind its serial port
`timescale 1ns/1ns
`default_nettype none
module dscfg_top
  import dscfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_sdio,
  input wire logic [15:0] i_temp_code,
  output logic o_sdo,
  output logic o_sdio,
  output logic o_sdio_oe,
  output dscfg_pwr_t o_pwr,
  output logic o_irq
);
  // Helper bounds for the checks below
  localparam int LOCK_WAIT = PLL_LOCK_CYC + 2;
  localparam int CONV_WAIT = TEMP_CONV_CYC + 2;

  typedef enum logic {TS_IDLE, TS_CONV} dscfg_ts_t;

  dscfg_acc_t acc;
  dscfg_ts_t ts_r;
  logic [7:0] rdata;
  logic [7:0] port_cfg_r;
  logic [7:0] pwr_ctrl_r;
  logic [7:0] clk_pwr_r;
  logic [7:0] sysref_r;
  logic [7:0] pll_en_r;
  logic [7:0] fb_div_r;
  logic [7:0] pll_pwrm_r;
  logic [7:0] temp_en_r;
  logic [7:0] irq_en_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic [7:0] gen_r [N_GEN];
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic [15:0] code_r;
  logic [7:0] tcnt_r;
  logic soft_rst;
  logic four_wire;
  logic pll_run;
  logic pll_locked;
  logic lock_evt;
  logic lost_evt;
  logic trig_start;
  logic tdone;
  dscfg_pwr_t pwr_r;

  ////////////////////////////////////////////////////////////////////////
  // Serial port; slow serial clock keeps the sampled pins coherent
  dscfg_spi u_spi (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_sclk(i_sclk),
    .i_csb_n(i_csb_n),
    .i_sdio(i_sdio),
    .i_four_wire(four_wire),
    .i_rdata(rdata),
    .o_acc(acc),
    .o_sdo(o_sdo),
    .o_sdio(o_sdio),
    .o_sdio_oe(o_sdio_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Port configuration survives soft reset so that it can release it
  // soft reset, port mode
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_cfg_r <= RST_PORT_CFG;
    end else if (hit(acc, A_PORT_CFG)) begin
      port_cfg_r <= acc.data;
    end
  end

  // Mirrored bits: either half of the pair acts
  assign soft_rst = port_cfg_r[PORT_RST_HI] | port_cfg_r[PORT_RST_LO];
  assign four_wire = port_cfg_r[PORT_4W_HI] | port_cfg_r[PORT_4W_LO];

  ////////////////////////////////////////////////////////////////////////
  // Power control; reset value keeps every block powered down
  // channel and reference enables
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_ctrl_r <= RST_PWR_CTRL;
    end else if (soft_rst) begin
      pwr_ctrl_r <= RST_PWR_CTRL;
    end else if (hit(acc, A_PWR_CTRL)) begin
      pwr_ctrl_r <= acc.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock tree and sysref receiver power
  // clock power-up writes
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_pwr_r <= RST_CLK_PWR;
      sysref_r <= RST_SYSREF;
    end else if (soft_rst) begin
      clk_pwr_r <= RST_CLK_PWR;
      sysref_r <= RST_SYSREF;
    end else begin
      if (hit(acc, A_CLK_PWR)) clk_pwr_r <= acc.data;
      if (hit(acc, A_SYSREF_CTL)) sysref_r <= acc.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL enable, feedback divider and power machine
  // power machine control
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pll_en_r <= RST_ZERO;
      fb_div_r <= RST_ZERO;
      pll_pwrm_r <= RST_PLL_PWRM;
    end else if (soft_rst) begin
      pll_en_r <= RST_ZERO;
      fb_div_r <= RST_ZERO;
      pll_pwrm_r <= RST_PLL_PWRM;
    end else begin
      if (hit(acc, A_PLL_EN)) pll_en_r <= acc.data;
      if (hit(acc, A_FB_DIV)) fb_div_r <= acc.data;
      if (hit(acc, A_PLL_PWRM)) pll_pwrm_r <= acc.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain settings; their values are only stored and read back here
  // filter and pump storage
  assign wr_idx = gen_idx(acc.addr);
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < N_GEN; i++) gen_r[i] <= RST_ZERO;
    end else if (soft_rst) begin
      for (int i = 0; i < N_GEN; i++) gen_r[i] <= RST_ZERO;
    end else if (acc.wr && wr_idx != GEN_NONE) begin
      gen_r[wr_idx] <= acc.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Loop may run only with clocks up, blocks powered and a divider set
  // feedback divider needed
  assign pll_run = pll_en_r[PLL_EN_BIT] && (pll_pwrm_r == RST_ZERO) &&
                   (clk_pwr_r == RST_ZERO) && (fb_div_r != RST_ZERO);

  dscfg_pll u_pll (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_run(pll_run),
    .o_locked(pll_locked),
    .o_lock_evt(lock_evt),
    .o_lost_evt(lost_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event flags; a new event beats a clear in the same cycle
  // sticky lock events
  always_comb begin
    irq_set = RST_ZERO;
    irq_set[IRQ_LOCK_BIT] = lock_evt & irq_en_r[IRQ_LOCK_BIT];
    irq_set[IRQ_LOST_BIT] = lost_evt & irq_en_r[IRQ_LOST_BIT];
    irq_clr = hit(acc, A_IRQ_STAT) ? (acc.data & IRQ_MASK) : RST_ZERO;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_en_r <= RST_ZERO;
      irq_stat_r <= RST_ZERO;
    end else if (soft_rst) begin
      irq_en_r <= RST_ZERO;
      irq_stat_r <= RST_ZERO;
    end else begin
      if (hit(acc, A_IRQ_EN)) irq_en_r <= acc.data & IRQ_MASK;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  assign o_irq = |irq_stat_r;

  ////////////////////////////////////////////////////////////////////////
  // Temperature sensor enable
  // sensor enable bit
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      temp_en_r <= RST_ZERO;
    end else if (soft_rst) begin
      temp_en_r <= RST_ZERO;
    end else if (hit(acc, A_TEMP_EN)) begin
      temp_en_r <= acc.data;
    end
  end

  // Trigger while disabled is dropped: there is nothing to sample
  // trigger starts conversion
  assign trig_start = hit(acc, A_TEMP_TRIG) && acc.data[TEMP_TRIG_BIT] &&
                      temp_en_r[TEMP_EN_BIT] && !soft_rst;
  assign tdone = (ts_r == TS_CONV) && (tcnt_r == 8'(TEMP_CONV_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer; a retrigger during conversion is ignored
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ts_r <= TS_IDLE;
      tcnt_r <= 8'h00;
    end else if (soft_rst || !temp_en_r[TEMP_EN_BIT]) begin
      ts_r <= TS_IDLE;
      tcnt_r <= 8'h00;
    end else begin
      unique case (ts_r)
        TS_IDLE: begin
          tcnt_r <= 8'h00;
          if (trig_start) ts_r <= TS_CONV;
        end
        TS_CONV: begin
          tcnt_r <= tcnt_r + 8'h01;
          if (tdone) ts_r <= TS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code held until the next conversion; cleared while disabled
  // no code when disabled
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code_r <= 16'h0000;
    end else if (soft_rst || !temp_en_r[TEMP_EN_BIT]) begin
      code_r <= 16'h0000;
    end else if (tdone) begin
      code_r <= i_temp_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power levels to the analog blocks, registered to avoid glitches
  // power-down bit decode
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_r <= '0;
    end else begin
      pwr_r.bandgap_en <= !pwr_ctrl_r[PWR_BG_PD];
      pwr_r.bias_en <= !pwr_ctrl_r[PWR_BIAS_PD];
      pwr_r.dac0_en <= !pwr_ctrl_r[PWR_DAC0_PD];
      pwr_r.dac1_en <= !pwr_ctrl_r[PWR_DAC1_PD];
      pwr_r.clk_en <= (clk_pwr_r == RST_ZERO);
      pwr_r.sysref_en <= (sysref_r == RST_ZERO);
      pwr_r.pll_locked <= pll_locked;
    end
  end

  assign o_pwr = pwr_r;

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped offsets read zero
  // link-layer offsets not held
  assign rd_idx = gen_idx(acc.addr);
  always_comb begin
    rdata = RST_ZERO;
    case (acc.addr)
      A_PORT_CFG: rdata = port_cfg_r;
      A_PWR_CTRL: rdata = pwr_ctrl_r;
      A_IRQ_EN: rdata = irq_en_r;
      A_IRQ_STAT: rdata = irq_stat_r;
      A_CLK_PWR: rdata = clk_pwr_r;
      A_SYSREF_CTL: rdata = sysref_r;
      A_PLL_EN: rdata = pll_en_r;
      A_PLL_STAT: rdata[PLL_LOCK_BIT] = pll_locked;
      A_FB_DIV: rdata = fb_div_r;
      A_TEMP_EN: rdata = temp_en_r;
      A_TEMP_LO: rdata = code_r[7:0];
      A_TEMP_HI: rdata = code_r[15:8];
      A_TEMP_TRIG: rdata[TEMP_TRIG_BIT] = (ts_r == TS_CONV);
      A_PLL_PWRM: rdata = pll_pwrm_r;
      default: begin
        if (rd_idx != GEN_NONE) rdata = gen_r[rd_idx];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_pwr_write_28;
    hit(acc, A_PWR_CTRL) && acc.data == 8'h28 && !soft_rst;
  endsequence
  sequence s_temp_trigger;
    trig_start && ts_r == TS_IDLE;
  endsequence
  sequence s_pll_starting;
    pll_run && !pll_locked;
  endsequence

  AST_SOFT_RST_HOLDS: assert property (
    soft_rst |=> pwr_ctrl_r == RST_PWR_CTRL && pll_en_r == RST_ZERO)
    else $error("soft reset did not restore registers");
  AST_PWR_28_ENABLES: assert property (
    s_pwr_write_28 |=> ##1 (pwr_r.bandgap_en && pwr_r.bias_en &&
                            pwr_r.dac0_en && pwr_r.dac1_en))
    else $error("power write 0x28 did not enable blocks");
  AST_CLK_ZERO_UP: assert property (
    hit(acc, A_CLK_PWR) && acc.data == 8'h00 && !soft_rst |=> ##1
    pwr_r.clk_en)
    else $error("clock power-up write had no effect");
  AST_DAC0_PD: assert property (
    pwr_ctrl_r[PWR_DAC0_PD] |=> !pwr_r.dac0_en)
    else $error("DAC0 power-down bit ignored");
  AST_PWRM_BLOCKS_RUN: assert property (
    pll_pwrm_r != RST_ZERO || fb_div_r == RST_ZERO |-> !pll_run)
    else $error("PLL ran without power or divider");
  AST_NO_LOCK_STOPPED: assert property (
    !pll_run |=> !pll_locked)
    else $error("lock reported while loop stopped");
  AST_LOCK_BOUNDED: assert property (
    s_pll_starting |-> ##[1:LOCK_WAIT] (pll_locked || !pll_run))
    else $error("lock not reached in settle time");
  AST_LOCK_NOT_EARLY: assert property (
    $rose(pll_run) |-> !pll_locked [*8])
    else $error("lock reported too early");
  AST_IRQ_STICKY: assert property (
    lock_evt && irq_en_r[IRQ_LOCK_BIT] && !soft_rst |=>
    irq_stat_r[IRQ_LOCK_BIT] && o_irq)
    else $error("lock event not latched");
  AST_TEMP_OFF_ZERO: assert property (
    !temp_en_r[TEMP_EN_BIT] |=> code_r == 16'h0000)
    else $error("code present with sensor disabled");
  AST_TEMP_DONE: assert property (
    s_temp_trigger |=> (ts_r == TS_CONV) ##[1:CONV_WAIT] ts_r == TS_IDLE)
    else $error("conversion did not finish in time");
  AST_STAT_READ: assert property (
    acc.rd && acc.addr == A_PLL_STAT |-> rdata == {6'h00, pll_locked, 1'b0})
    else $error("status readback wrong");

endmodule : dscfg_top
`default_nettype wire

// ==== dscfg_host.sv ====
// Host model: drives whole configuration frames on the serial port pins
`timescale 1ns/1ns
`default_nettype none
module dscfg_host (
  input wire logic i_clk_sys,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_csb_n,
  output logic o_sdio
);
  // Half period in sys cycles; margin over the least of 5 for read latency
  localparam int HALF = 8;

  // Idle pins at time zero
  initial begin
    o_sclk = 1'b0;
    o_csb_n = 1'b1;
    o_sdio = 1'b0;
  end

  // Pins always move just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask : tick

  task automatic xfer(input logic rd, input logic [14:0] a,
    input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] f;
    f = {rd, a, wd};
    rdat = 8'h00;
    o_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // Released line toggles so a stale bit never looks valid
      o_sdio = (rd && i < 8) ? ~o_sdio : f[i];
      tick(HALF);
      o_sclk = 1'b1;
      if (i < 8) begin
        rdat[i] = i_sdo;
      end
      tick(HALF);
      o_sclk = 1'b0;
    end
    tick(HALF);
    o_csb_n = 1'b1;
    tick(2 * HALF);
  endtask : xfer
endmodule : dscfg_host
`default_nettype wire

// ==== tb.sv ====
// Testbench: start-up register sequence through the serial port
`timescale 1ns/1ns
`default_nettype none
module tb
  import dscfg_pkg::*;
;
  logic clk, arst_n, sclk, csb_n, h_sdio, sdo, sdio_o, sdio_oe, irq;
  logic sdio_w;
  logic [15:0] temp_code;
  dscfg_pwr_t pwr;
  int fails = 0;
  int n_tests = 0;

  // Shared data line: the device wins while it drives
  assign sdio_w = sdio_oe ? sdio_o : h_sdio;

  dscfg_top dscfg_top_inst (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_sclk(sclk), .i_csb_n(csb_n), .i_sdio(sdio_w),
    .i_temp_code(temp_code), .o_sdo(sdo), .o_sdio(sdio_o),
    .o_sdio_oe(sdio_oe), .o_pwr(pwr), .o_irq(irq));
  dscfg_host dscfg_host_inst (.i_clk_sys(clk),
    .i_sdo(sdio_oe ? sdio_o : sdo), .o_sclk(sclk), .o_csb_n(csb_n),
    .o_sdio(h_sdio));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  //////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    dscfg_host_inst.xfer(1'b0, a, d, x);
  endtask : wr

  task automatic rchk(input string nm, input logic [14:0] a,
    input logic [7:0] e);
    logic [7:0] d;
    dscfg_host_inst.xfer(1'b1, a, 8'h00, d);
    chk(nm, e, d);
  endtask : rchk

  task automatic t_reset;
    chk("pwr", 8'h00, {1'b0, pwr});
    chk("irq", 8'h00, {7'h00, irq});
    rchk("pwr_ctrl", A_PWR_CTRL, RST_PWR_CTRL);
    rchk("clk_pwr", A_CLK_PWR, RST_CLK_PWR);
    rchk("pll_pwrm", A_PLL_PWRM, RST_PLL_PWRM);
  endtask : t_reset

  // Soft reset must drop settings written before it
  task automatic t_soft;
    wr(A_PWR_CTRL, 8'h28);
    chk("pwr", 8'h78, {1'b0, pwr});
    wr(A_PORT_CFG, 8'hBD);
    chk("pwr", 8'h00, {1'b0, pwr});
    wr(A_PWR_CTRL, 8'h28);
    rchk("pwr_ctrl", A_PWR_CTRL, RST_PWR_CTRL);
    wr(A_PORT_CFG, 8'h3C);
    rchk("port_cfg", A_PORT_CFG, 8'h3C);
  endtask : t_soft

  task automatic t_power;
    logic [7:0] v[5] = '{8'h28, 8'h68, 8'h38, 8'h84, 8'h28};
    logic [7:0] e[5] = '{8'h78, 8'h68, 8'h70, 8'h18, 8'h78};
    for (int i = 0; i < 5; i++) begin
      wr(A_PWR_CTRL, v[i]);
      chk("pwr", e[i], {1'b0, pwr});
    end
  endtask : t_power

  task automatic t_clocks;
    logic [14:0] a[4] = '{15'h12D, 15'h146, 15'h2A4, 15'h232};
    logic [7:0] v[4] = '{8'h8B, 8'h01, 8'hFF, 8'hFF};
    wr(A_CLK_PWR, 8'h00);
    wr(A_SYSREF_CTL, 8'h00);
    chk("pwr", 8'h7E, {1'b0, pwr});
    // Mandatory datapath, clock and lane values, each read back
    for (int i = 0; i < 4; i++) begin
      wr(a[i], v[i]);
      rchk("mandatory", a[i], v[i]);
    end
    wr(15'h333, 8'h01);
    rchk("lane_b", 15'h333, 8'h01);
  endtask : t_clocks

  // Lock needs the divider; then lock and loss events
  task automatic t_pll;
    logic [7:0] d;
    logic [14:0] a[10] = '{15'h088, 15'h089, 15'h08A, 15'h08D, 15'h1C0,
      15'h08B, 15'h08C, 15'h1B5, 15'h1BB, 15'h1C5};
    logic [7:0] v[10] = '{8'hC9, 8'h0E, 8'h12, 8'h7B, 8'h2A, 8'h02, 8'h03,
      8'h09, 8'h13, 8'h06};
    wr(A_IRQ_EN, IRQ_MASK);
    wr(15'h087, 8'h62);
    // Filter, pump, regulator, lock length, dividers, lookups before enable
    for (int i = 0; i < 10; i++) begin
      wr(a[i], v[i]);
      rchk("pll_setting", a[i], v[i]);
    end
    wr(A_PLL_PWRM, 8'h00);
    wr(A_PLL_EN, 8'h10);
    cyc(PLL_LOCK_CYC + 20);
    chk("no_lock", 8'h7E, {1'b0, pwr});
    wr(A_FB_DIV, 8'h10);
    d = 8'h00;
    for (int k = 0; k < 8 && d[PLL_LOCK_BIT] !== 1'b1; k++) begin
      dscfg_host_inst.xfer(1'b1, A_PLL_STAT, 8'h00, d);
    end
    chk("lock_bit", 8'h01, {7'h00, d[PLL_LOCK_BIT]});
    chk("pwr", 8'h7F, {1'b0, pwr});
    chk("irq", 8'h01, {7'h00, irq});
    rchk("irq_stat", A_IRQ_STAT, 8'h10);
    wr(A_IRQ_STAT, 8'h10);
    chk("irq", 8'h00, {7'h00, irq});
    wr(A_PLL_EN, 8'h00);
    chk("pwr", 8'h7E, {1'b0, pwr});
    rchk("irq_stat", A_IRQ_STAT, 8'h20);
    rchk("loop_filt", 15'h087, 8'h62);
  endtask : t_pll

  // Trigger is ignored until the sensor is enabled
  task automatic t_temp;
    logic [7:0] lo;
    logic [7:0] hi;
    int dt;
    temp_code = 16'hA5C3;
    wr(A_TEMP_TRIG, 8'h01);
    rchk("temp_lo", A_TEMP_LO, 8'h00);
    wr(A_TEMP_EN, 8'h01);
    wr(A_TEMP_TRIG, 8'h01);
    rchk("temp_lo", A_TEMP_LO, 8'hC3);
    rchk("temp_hi", A_TEMP_HI, 8'hA5);
    temp_code = 16'h0102;
    wr(A_TEMP_LO, 8'h55);
    wr(A_TEMP_TRIG, 8'h01);
    rchk("temp_lo", A_TEMP_LO, 8'h02);
    rchk("temp_hi", A_TEMP_HI, 8'h01);
    // Step from the first (reference) code, in hundredths of a degree
    dscfg_host_inst.xfer(1'b1, A_TEMP_LO, 8'h00, lo);
    dscfg_host_inst.xfer(1'b1, A_TEMP_HI, 8'h00, hi);
    dt = 73 * (int'({hi, lo}) - int'(16'hA5C3)) / 100;
    n_tests++;
    if (dt != -30789) begin
      fails++;
      $display("BAD temp_step expected %0d seen %0d", -30789, dt);
    end
    wr(15'h7FF, 8'hAA);
    rchk("unmapped", 15'h7FF, 8'h00);
  endtask : t_temp

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    arst_n = 1'b0;
    temp_code = 16'h0000;
    repeat (10) @(posedge clk);
    #2;
    arst_n = 1'b1;
    cyc(4);
    t_reset();
    t_soft();
    t_power();
    t_clocks();
    t_pll();
    t_temp();
    test_done();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("BAD watchdog expected done seen hang");
    test_done();
  end
endmodule : tb
`default_nettype wire
